// [inc/cesc_consts.svh]
/*
 * Constants for the charger-emulation stimulus configuration bank:
 * register offsets, field positions, reset values and field codes.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef CESC_CONSTS_SVH
`define CESC_CONSTS_SVH

// ***************************************************************
// Register offsets and reset values
// ***************************************************************
`define CESC_ADDR_S2TP      8'h37
`define CESC_ADDR_S2DR      8'h38
`define CESC_ADDR_S3TD      8'h39
`define CESC_RST_S2TP       6'h00
`define CESC_RST_S2DR       3'h0
`define CESC_RST_S3TD       7'h00
`define CESC_RD_ZERO        8'h00

// ***************************************************************
// Field positions
// ***************************************************************
`define CESC_S2TP_MSB       5
`define CESC_S2TP_PD_MSB    5
`define CESC_S2TP_PD_LSB    4
`define CESC_S2TP_TH_MSB    3
`define CESC_S2DR_MSB       2
`define CESC_S3TD_MSB       6
`define CESC_S3TD_TYPE_BIT  6
`define CESC_S3TD_DEL_MSB   5
`define CESC_S3TD_DEL_LSB   3
`define CESC_S3TD_DET_MSB   2

// ***************************************************************
// Field codes
// ***************************************************************
`define CESC_RATIO_RSVD     3'h7
`define CESC_DET_RSVD_A     3'h4
`define CESC_DET_RSVD_B     3'h5
`define CESC_RESP_DIV_DP    4'h6
`define CESC_RESP_DIV_DM    4'h9
`define CESC_RESP_DIV_BOTH  4'hC

// Divider ratio in hundredths
`define CESC_PCT_0          7'd25
`define CESC_PCT_1          7'd33
`define CESC_PCT_2          7'd40
`define CESC_PCT_3          7'd50
`define CESC_PCT_4          7'd54
`define CESC_PCT_5          7'd60
`define CESC_PCT_6          7'd66
`define CESC_PCT_NONE       7'd0

// Stimulus 3 timer length in milliseconds
`define CESC_MS_0           7'd0
`define CESC_MS_1           7'd1
`define CESC_MS_2           7'd5
`define CESC_MS_3           7'd10
`define CESC_MS_4           7'd20
`define CESC_MS_5           7'd40
`define CESC_MS_6           7'd80
`define CESC_MS_7           7'd100

`endif

// [inc/cesc_pkg.sv]
/*
 * Types shared by the stimulus configuration bank.
 * Assumes nothing of its surroundings.
 */
package cesc_pkg;

    // Which emulation profile family the sequencer is applying
    typedef enum logic [1:0] {
        CESC_PROF_NONE,
        CESC_PROF_LEGACY,
        CESC_PROF_BC12
    } cesc_profile_t;

endpackage

// [verilog/cesc_cfg_cell.sv]
/*
 * One configuration field register with write enable.
 * Assumes the caller has already decided whether the write is accepted.
 */
`timescale 1ns/1ps

module cesc_cfg_cell
    import cesc_pkg::*;
#(
    parameter int          W   = 8,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Write side
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wdata,
    // Stored value
    output logic      [W-1:0] q
);

    // ***********************************************************
    // Storage
    // ***********************************************************

    // Holds its value unless an accepted write arrives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST;
        end else if (wr_en) begin
            q <= wdata;
        end
    end

endmodule

// [verilog/cesc_stim_cfg.sv]
/*
 * Stimulus 2 / stimulus 3 configuration bank for charger emulation.
 * Assumes a synchronous register port from the device's register
 * interface and a sequencer that loads profile settings by pulse.
 */
// Functional notes
// - Ratio codes map 0.25 through 0.66; 111 reserved
// - Ratio applies only for divider response codes
// - BC1.2 profiles leave divider ratio untouched
// - Legacy profiles leave pull-down and threshold untouched
// - Ratio register upper five bits read zero
// - Reserved-code writes rejected, field keeps value
`timescale 1ns/1ps
`include "cesc_consts.svh"

module cesc_stim_cfg
    import cesc_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Register port
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    output logic      [7:0]    reg_rdata_r,
    output logic               reg_rd_valid_r,
    output logic               wr_reject_r,
    // Sequencer profile load
    input  wire logic          seq_load,
    input  cesc_profile_t      cur_profile,
    input  wire logic [7:0]    load_s2tp,
    input  wire logic [7:0]    load_s2dr,
    input  wire logic [7:0]    load_s3td,
    input  wire logic [3:0]    stim2_response_select,
    // Field outputs to the sequencer
    output logic      [1:0]    stim2_pulldown_current,
    output logic      [3:0]    stim2_threshold,
    output logic      [2:0]    stim2_divider_ratio,
    output logic               stim3_timer_behaviour,
    output logic      [2:0]    stim3_delay_select,
    output logic      [2:0]    stim3_detect_type,
    // Decoded settings
    output logic               divider_en_r,
    output logic      [6:0]    ratio_pct_r,
    output logic      [6:0]    delay_ms_r
);

    // ***********************************************************
    // Decode functions
    // ***********************************************************

    function automatic logic det_ok(input logic [2:0] c);
        det_ok = (c != `CESC_DET_RSVD_A) && (c != `CESC_DET_RSVD_B);
    endfunction

    function automatic logic [6:0] ratio_pct(input logic [2:0] c);
        unique case (c)
            3'h0:    ratio_pct = `CESC_PCT_0;
            3'h1:    ratio_pct = `CESC_PCT_1;
            3'h2:    ratio_pct = `CESC_PCT_2;
            3'h3:    ratio_pct = `CESC_PCT_3;
            3'h4:    ratio_pct = `CESC_PCT_4;
            3'h5:    ratio_pct = `CESC_PCT_5;
            3'h6:    ratio_pct = `CESC_PCT_6;
            3'h7:    ratio_pct = `CESC_PCT_NONE;
        endcase
    endfunction

    function automatic logic [6:0] delay_ms(input logic [2:0] c);
        unique case (c)
            3'h0:    delay_ms = `CESC_MS_0;
            3'h1:    delay_ms = `CESC_MS_1;
            3'h2:    delay_ms = `CESC_MS_2;
            3'h3:    delay_ms = `CESC_MS_3;
            3'h4:    delay_ms = `CESC_MS_4;
            3'h5:    delay_ms = `CESC_MS_5;
            3'h6:    delay_ms = `CESC_MS_6;
            3'h7:    delay_ms = `CESC_MS_7;
        endcase
    endfunction

    // ***********************************************************
    // Write decode
    // ***********************************************************

    logic [5:0] s2tp_q;
    logic [2:0] s2dr_q;
    logic [6:0] s3td_q;

    // Software write strobes per register
    wire sw_s2tp = reg_wr && (reg_addr == `CESC_ADDR_S2TP);
    wire sw_s2dr = reg_wr && (reg_addr == `CESC_ADDR_S2DR);
    wire sw_s3td = reg_wr && (reg_addr == `CESC_ADDR_S3TD);

    // Profile loads touch only the fields that profile family uses
    wire ld_s2tp = seq_load && (cur_profile == CESC_PROF_BC12);
    wire ld_s2dr = seq_load && (cur_profile == CESC_PROF_LEGACY);
    wire ld_s3td = seq_load && (cur_profile != CESC_PROF_NONE);

    // Reserved-code screening on each writer
    wire sw_dr_ok = reg_wdata[`CESC_S2DR_MSB:0] != `CESC_RATIO_RSVD;
    wire ld_dr_ok = load_s2dr[`CESC_S2DR_MSB:0] != `CESC_RATIO_RSVD;
    wire sw_td_ok = det_ok(reg_wdata[`CESC_S3TD_DET_MSB:0]);
    wire ld_td_ok = det_ok(load_s3td[`CESC_S3TD_DET_MSB:0]);

    // Software wins when both writers hit one register in a cycle
    wire       s2tp_we = sw_s2tp || ld_s2tp;
    wire [5:0] s2tp_wd = sw_s2tp ? reg_wdata[`CESC_S2TP_MSB:0]
                                 : load_s2tp[`CESC_S2TP_MSB:0];
    wire       s2dr_we = (sw_s2dr && sw_dr_ok) || (!sw_s2dr && ld_s2dr && ld_dr_ok);
    wire [2:0] s2dr_wd = sw_s2dr ? reg_wdata[`CESC_S2DR_MSB:0]
                                 : load_s2dr[`CESC_S2DR_MSB:0];
    wire       s3td_we = (sw_s3td && sw_td_ok) || (!sw_s3td && ld_s3td && ld_td_ok);
    wire [6:0] s3td_wd = sw_s3td ? reg_wdata[`CESC_S3TD_MSB:0]
                                 : load_s3td[`CESC_S3TD_MSB:0];

    wire rejected = (sw_s2dr && !sw_dr_ok) || (sw_s3td && !sw_td_ok);

    // ***********************************************************
    // Field storage
    // ***********************************************************

    cesc_cfg_cell #(.W(6), .RST(`CESC_RST_S2TP)) u_s2tp (
        .clk   (clk),
        .rst_n (rst_n),
        .wr_en (s2tp_we),
        .wdata (s2tp_wd),
        .q     (s2tp_q)
    );

    cesc_cfg_cell #(.W(3), .RST(`CESC_RST_S2DR)) u_s2dr (
        .clk   (clk),
        .rst_n (rst_n),
        .wr_en (s2dr_we),
        .wdata (s2dr_wd),
        .q     (s2dr_q)
    );

    cesc_cfg_cell #(.W(7), .RST(`CESC_RST_S3TD)) u_s3td (
        .clk   (clk),
        .rst_n (rst_n),
        .wr_en (s3td_we),
        .wdata (s3td_wd),
        .q     (s3td_q)
    );

    // Fields straight from the cell flops
    assign stim2_pulldown_current = s2tp_q[`CESC_S2TP_PD_MSB:`CESC_S2TP_PD_LSB];
    assign stim2_threshold        = s2tp_q[`CESC_S2TP_TH_MSB:0];
    assign stim2_divider_ratio    = s2dr_q;
    assign stim3_timer_behaviour  = s3td_q[`CESC_S3TD_TYPE_BIT];
    assign stim3_delay_select     = s3td_q[`CESC_S3TD_DEL_MSB:`CESC_S3TD_DEL_LSB];
    assign stim3_detect_type      = s3td_q[`CESC_S3TD_DET_MSB:0];

    // ***********************************************************
    // Read path
    // ***********************************************************

    // Unimplemented bits are padded with zero; unmapped reads give zero
    wire [7:0] rd_mux =
        (reg_addr == `CESC_ADDR_S2TP) ? {2'b00, s2tp_q} :
        (reg_addr == `CESC_ADDR_S2DR) ? {5'b00000, s2dr_q} :
        (reg_addr == `CESC_ADDR_S3TD) ? {1'b0, s3td_q} :
                                        `CESC_RD_ZERO;

    // Read data held until the next read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r    <= `CESC_RD_ZERO;
            reg_rd_valid_r <= 1'b0;
            wr_reject_r    <= 1'b0;
        end else begin
            reg_rdata_r    <= reg_rd ? rd_mux : reg_rdata_r;
            reg_rd_valid_r <= reg_rd;
            wr_reject_r    <= rejected;
        end
    end

    // ***********************************************************
    // Decoded settings
    // ***********************************************************

    // Divider only meaningful for divider responses under legacy profiles
    wire resp_div = (stim2_response_select == `CESC_RESP_DIV_DP)
                 || (stim2_response_select == `CESC_RESP_DIV_DM)
                 || (stim2_response_select == `CESC_RESP_DIV_BOTH);
    wire div_en_nxt = resp_div && (cur_profile == CESC_PROF_LEGACY);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divider_en_r <= 1'b0;
            ratio_pct_r  <= `CESC_PCT_NONE;
            delay_ms_r   <= `CESC_MS_0;
        end else begin
            divider_en_r <= div_en_nxt;
            ratio_pct_r  <= div_en_nxt ? ratio_pct(s2dr_q) : `CESC_PCT_NONE;
            delay_ms_r   <= delay_ms(stim3_delay_select);
        end
    end

    // ***********************************************************
    // Checks
    // ***********************************************************

    chk_ratio_map: assert property (@(posedge clk) disable iff (!rst_n)
        (div_en_nxt && s2dr_q == 3'h4) |=> (ratio_pct_r == `CESC_PCT_4))
        else $error("ratio code 100 not mapped to 0.54");

    chk_div_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (!resp_div || cur_profile != CESC_PROF_LEGACY)
        |=> !divider_en_r && ratio_pct_r == `CESC_PCT_NONE)
        else $error("divider ratio applied outside divider response");

    chk_bc12_ratio: assert property (@(posedge clk) disable iff (!rst_n)
        (seq_load && cur_profile == CESC_PROF_BC12 && !sw_s2dr) |=> $stable(s2dr_q))
        else $error("BC1.2 load changed divider ratio");

    chk_legacy_s2tp: assert property (@(posedge clk) disable iff (!rst_n)
        (seq_load && cur_profile == CESC_PROF_LEGACY && !sw_s2tp) |=> $stable(s2tp_q))
        else $error("legacy load changed pull-down or threshold");

    chk_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `CESC_ADDR_S2DR)
        |=> reg_rdata_r[7:3] == 5'h00 && reg_rdata_r[2:0] == $past(s2dr_q))
        else $error("ratio register read wrong");

    chk_rsvd_keep: assert property (@(posedge clk) disable iff (!rst_n)
        (sw_s2dr && reg_wdata[`CESC_S2DR_MSB:0] == `CESC_RATIO_RSVD)
        |=> $stable(s2dr_q) && wr_reject_r)
        else $error("reserved ratio write accepted");

    chk_delay_map: assert property (@(posedge clk) disable iff (!rst_n)
        (stim3_delay_select == 3'h7) |=> (delay_ms_r == `CESC_MS_7))
        else $error("delay code 111 not 100 ms");

endmodule

// [test/tb.sv]
/*
 * Self-checking bench for the stimulus configuration bank.
 * Assumes the design files and the constants header are compiled first.
 */
`timescale 1ns/1ps

module tb
    import cesc_pkg::*;
;
    // ***************************************************************
    // Signals
    // ***************************************************************
    logic          clk;
    logic          rst_n;
    logic          reg_wr;
    logic          reg_rd;
    logic [7:0]    reg_addr;
    logic [7:0]    reg_wdata;
    logic [7:0]    reg_rdata_r;
    logic          reg_rd_valid_r;
    logic          wr_reject_r;
    logic          seq_load;
    cesc_profile_t prof;
    logic [7:0]    load_s2tp;
    logic [7:0]    load_s2dr;
    logic [7:0]    load_s3td;
    logic [3:0]    resp;
    logic [1:0]    pd_cur;
    logic [3:0]    thr;
    logic [2:0]    ratio;
    logic          tmr_kind;
    logic [2:0]    dly_sel;
    logic [2:0]    det;
    logic          div_en;
    logic [6:0]    pct;
    logic [6:0]    dms;
    int            n_errors;
    int            check_count;
    logic          rej;
    logic [7:0]    pct_tab [0:6] = '{8'h19, 8'h21, 8'h28, 8'h32, 8'h36, 8'h3C, 8'h42};
    logic [7:0]    ms_tab [0:7]  = '{8'h00, 8'h01, 8'h05, 8'h0A, 8'h14, 8'h28, 8'h50, 8'h64};
    logic [7:0]    v;

    cesc_stim_cfg dut_u (
        .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .reg_rd_valid_r(reg_rd_valid_r), .wr_reject_r(wr_reject_r),
        .seq_load(seq_load), .cur_profile(prof), .load_s2tp(load_s2tp),
        .load_s2dr(load_s2dr), .load_s3td(load_s3td), .stim2_response_select(resp),
        .stim2_pulldown_current(pd_cur), .stim2_threshold(thr),
        .stim2_divider_ratio(ratio), .stim3_timer_behaviour(tmr_kind),
        .stim3_delay_select(dly_sel), .stim3_detect_type(det),
        .divider_en_r(div_en), .ratio_pct_r(pct), .delay_ms_r(dms)
    );

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ***************************************************************
    // Access tasks, all driven at the falling edge
    // ***************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Write strobe lasts one cycle; reject flag is read the cycle after
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic r);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        r = wr_reject_r;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk({7'h00, reg_rd_valid_r}, 8'h01);
        chk(reg_rdata_r, exp);
        // Valid stands for one cycle only
        @(negedge clk);
        chk({7'h00, reg_rd_valid_r}, 8'h00);
    endtask

    task automatic ld(input cesc_profile_t p, input logic [7:0] tp, dr, td);
        @(negedge clk);
        prof = p;
        load_s2tp = tp;
        load_s2dr = dr;
        load_s3td = td;
        seq_load = 1'b1;
        @(negedge clk);
        seq_load = 1'b0;
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ***************************************************************
    // Main sequence
    // ***************************************************************
    initial begin
        {rst_n, reg_wr, reg_rd, seq_load} = 4'h0;
        {reg_addr, reg_wdata, load_s2tp, load_s2dr, load_s3td} = 40'h00;
        resp = 4'h0;
        prof = CESC_PROF_NONE;
        n_errors = 0;
        check_count = 0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        rd(8'h37, 8'h00);
        rd(8'h38, 8'h00);
        rd(8'h39, 8'h00);
        // Every ratio code with a divider response under a legacy profile
        prof = CESC_PROF_LEGACY;
        resp = 4'h6;
        for (int i = 0; i < 7; i++) begin
            wr(8'h38, 8'(i), rej);
            chk({7'h00, rej}, 8'h00);
            @(negedge clk);
            chk({1'b0, pct}, pct_tab[i]);
            rd(8'h38, 8'(i));
        end
        wr(8'h38, 8'hFF, rej);
        chk({7'h00, rej}, 8'h01);
        rd(8'h38, 8'h06);
        wr(8'h38, 8'hF9, rej);
        rd(8'h38, 8'h01);
        // Divider only for the three divider responses
        for (int r = 0; r < 16; r++) begin
            resp = 4'(r);
            repeat (2) @(negedge clk);
            v = (r == 6 || r == 9 || r == 12) ? 8'h21 : 8'h00;
            chk({7'h00, div_en}, {7'h00, v[0]});
            chk({1'b0, pct}, v);
        end
        resp = 4'h6;
        prof = CESC_PROF_BC12;
        repeat (2) @(negedge clk);
        chk({7'h00, div_en}, 8'h00);
        // Delay codes, timer kind and bit 7 ignored
        for (int d = 0; d < 8; d++) begin
            v = {2'b01, 3'(d), 3'h1};
            wr(8'h39, v | 8'h80, rej);
            @(negedge clk);
            chk({1'b0, dms}, ms_tab[d]);
            chk({1'b0, tmr_kind, dly_sel, det}, v);
            rd(8'h39, v);
        end
        for (int k = 4; k < 6; k++) begin
            wr(8'h39, 8'(k), rej);
            chk({7'h00, rej}, 8'h01);
            rd(8'h39, 8'h79);
        end
        wr(8'h37, 8'hFF, rej);
        rd(8'h37, 8'h3F);
        wr(8'h40, 8'hFF, rej);
        rd(8'h40, 8'h00);
        // Profile loads touch only their own family's fields
        ld(CESC_PROF_BC12, 8'h15, 8'h03, 8'h0A);
        chk({5'h00, ratio}, 8'h01);
        chk({2'b00, pd_cur, thr}, 8'h15);
        chk({1'b0, tmr_kind, dly_sel, det}, 8'h0A);
        ld(CESC_PROF_LEGACY, 8'h2A, 8'h04, 8'h11);
        chk({2'b00, pd_cur, thr}, 8'h15);
        chk({5'h00, ratio}, 8'h04);
        chk({1'b0, tmr_kind, dly_sel, det}, 8'h11);
        ld(CESC_PROF_LEGACY, 8'h00, 8'h07, 8'h11);
        chk({5'h00, ratio}, 8'h04);
        // A load with no profile family touches nothing
        ld(CESC_PROF_NONE, 8'h3F, 8'h02, 8'h3B);
        chk({2'b00, pd_cur, thr}, 8'h15);
        chk({5'h00, ratio}, 8'h04);
        chk({1'b0, tmr_kind, dly_sel, det}, 8'h11);
        // Second reset in mid-run clears the bank
        rst_n = 1'b0;
        @(negedge clk);
        chk({5'h00, ratio}, 8'h00);
        chk({1'b0, dms}, 8'h00);
        rst_n = 1'b1;
        rd(8'h39, 8'h00);
        report_and_stop();
    end
endmodule
